// >>> core/cpm_pkg.sv
// package of constants and carriers for the core programming model register file
package cpm_pkg;

  // ----------------------------------------------------------------
  // widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned REG_W      = 32;  // general register width
  localparam int unsigned BUS_W      = 16;  // external data path width
  localparam int unsigned NUM_DATA   = 8;
  localparam int unsigned NUM_ADDR   = 8;
  localparam int unsigned IDX_W      = 4;   // sixteen general registers
  localparam logic [2:0]  STACK_AREG = 3'h7;
  localparam int unsigned SR_T_BIT   = 15;  // trace indication
  localparam int unsigned SR_S_BIT   = 13;  // supervisor indication
  localparam int unsigned SR_IM_LO   = 8;   // interrupt mask field
  localparam int unsigned SR_IM_HI   = 10;
  localparam int unsigned CF_X       = 4;
  localparam int unsigned CF_N       = 3;
  localparam int unsigned CF_Z       = 2;
  localparam int unsigned CF_V       = 1;
  localparam int unsigned CF_C       = 0;
  localparam logic [15:0] SR_RST     = 16'h2700;  // supervisor, mask 7
  localparam logic [15:0] SR_IMPL    = 16'ha71f;  // implemented bits
  localparam logic [31:0] PC_RST     = 32'h0000_0000;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  localparam logic [2:0]  STEP_B     = 3'h1;
  localparam logic [2:0]  STEP_W     = 3'h2;
  localparam logic [2:0]  STEP_L     = 3'h4;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SZ_BIT  = 3'b000,
    SZ_BCD  = 3'b001,
    SZ_BYTE = 3'b010,
    SZ_WORD = 3'b011,
    SZ_LONG = 3'b100
  } cpm_size_t;

  typedef enum logic [3:0] {
    EA_DREG  = 4'b0000,
    EA_AREG  = 4'b0001,
    EA_IND   = 4'b0010,
    EA_POST  = 4'b0011,
    EA_PRE   = 4'b0100,
    EA_DISP  = 4'b0101,
    EA_INDEX = 4'b0110,
    EA_ABSW  = 4'b0111,
    EA_ABSL  = 4'b1000,
    EA_PCD   = 4'b1001,
    EA_PCX   = 4'b1010,
    EA_IMM   = 4'b1011,
    EA_QUICK = 4'b1100
  } cpm_mode_t;

  typedef enum logic [1:0] {
    XF_IDLE = 2'b00,
    XF_HI   = 2'b01,
    XF_LO   = 2'b10
  } cpm_xfer_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;     // write enable
    logic        is_addr;
    logic [2:0]  num;
    cpm_size_t   size;
    logic [31:0] data;
  } cpm_reg_wr_t;

  typedef struct packed {
    logic        start;  // one-cycle request
    cpm_mode_t   mode;
    cpm_size_t   size;
    logic [2:0]  areg;
    logic [3:0]  xidx;   // msb set selects an address register
    logic        xlong;  // long index, else sign-extended word
    logic [7:0]  d8;
    logic [15:0] ext0;   // first extension word
    logic [15:0] ext1;   // second extension word
    logic [7:0]  quick;  // constant from the operation word
  } cpm_ea_req_t;

  typedef struct packed {
    logic        wr;
    logic [4:0]  cond_flag_byte;    // x n z v c
  } cpm_flag_wr_t;

endpackage : cpm_pkg

// >>> core/cpm_regfile.sv
// architectural register file and effective address unit of the core
// ----------------------------------------------------------------
// Operation
// - 32-bit registers move over 16-bit path; long words take two accesses.
// - eight data registers written at byte, word or long size.
// - address registers take word (sign-extended) or long writes, never byte.
// - any of sixteen registers may be the index register.
// - in user privilege the eighth address register is the user stack pointer.
// - in supervisor privilege it is a separate supervisor stack pointer.
// - 32-bit program counter readable in both privilege levels.
// - condition byte holds extend, negative, zero, overflow, carry flags.
// - condition byte is status word low byte, writable from user privilege.
// - high status byte holds three-bit interrupt mask, supervisor only.
// - status word shows trace and supervisor indications.
// - privileged operations are refused outside supervisor privilege.
// - operand size is bit, decimal byte, byte, word or long.
// - integer operands are two's complement; flags from signed result.
// - indirect, post-increment, pre-decrement, displacement and indexed modes.
// - program counter plus 16-bit displacement, or plus index and 8-bit one.
// - absolute short from next word, absolute long from next two words.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module cpm_regfile
  import cpm_pkg::*;
(
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire cpm_reg_wr_t  reg_wr_i,
  input  wire logic [3:0]   rd_idx_i,
  input  wire cpm_flag_wr_t flag_wr_i,
  input  wire logic         sr_wr_i,
  input  wire logic [15:0]  sr_data_i,
  input  wire logic         priv_op_i,
  input  wire logic         pc_wr_i,
  input  wire logic [31:0]  pc_data_i,
  input  wire cpm_ea_req_t  ea_req_i,
  input  wire logic         xfer_start_i,
  input  wire logic [31:0]  xfer_data_i,
  output logic [31:0]       rd_data_o,
  output logic [31:0]       program_counter_o,
  output logic [15:0]       status_word_o,
  output logic [31:0]       effective_address_o,
  output logic [31:0]       imm_data_o,
  output logic              ea_valid_o,
  output logic              priv_viol_o,
  output logic [15:0]       bus_data_o,
  output logic              bus_strobe_o,
  output logic              xfer_busy_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // merge a write into a register at the given size
  function automatic logic [31:0] size_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input cpm_size_t   sz);
    case (sz) // bit and decimal sizes merge as a byte
      SZ_LONG: size_merge = nw;
      SZ_WORD: size_merge = {old[31:16], nw[15:0]};
      default: size_merge = {old[31:8], nw[7:0]};
    endcase
  endfunction : size_merge

  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction : sext16

  function automatic logic [31:0] sext8(input logic [7:0] v);
    sext8 = {{24{v[7]}}, v};
  endfunction : sext8

  // step in bytes for post-increment and pre-decrement
  function automatic logic [31:0] step_of(input cpm_size_t sz, input logic [2:0] an);
    logic [2:0] s;
    s = STEP_B;
    case (sz)
      SZ_LONG: s = STEP_L;
      SZ_WORD: s = STEP_W;
      default: s = (an == STACK_AREG) ? STEP_W : STEP_B;
    endcase
    step_of = {29'h0, s};
  endfunction : step_of

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] data_regs [NUM_DATA];
  logic [31:0] addr_regs [NUM_ADDR-1];
  logic [31:0] user_stack_ptr_q;
  logic [31:0] supv_stack_ptr_q;
  logic [31:0] program_counter_q;
  logic [15:0] status_word_q;
  logic        supv;

  assign supv = status_word_q[SR_S_BIT];

  // read any address register through the privilege bank
  function automatic logic [31:0] areg_rd(input logic [2:0] n);
    if (n == STACK_AREG) begin
      areg_rd = supv ? supv_stack_ptr_q : user_stack_ptr_q;
    end else begin
      areg_rd = addr_regs[n];
    end
  endfunction : areg_rd

  function automatic logic [31:0] gen_rd(input logic [3:0] idx);
    gen_rd = idx[3] ? areg_rd(idx[2:0]) : data_regs[idx[2:0]];
  endfunction : gen_rd

  // ----------------------------------------------------------------
  // effective address computation
  // ----------------------------------------------------------------
  logic [31:0] base_a;
  logic [31:0] xval;
  logic [31:0] ea_d;
  logic [31:0] imm_d;
  logic        an_upd;
  logic [31:0] an_new;

  always_comb begin
    base_a = areg_rd(ea_req_i.areg);
    xval   = gen_rd(ea_req_i.xidx);
    if (!ea_req_i.xlong) begin
      xval = sext16(xval[15:0]);
    end
    ea_d   = ZERO32;
    imm_d  = ZERO32;
    an_upd = 1'b0;
    an_new = base_a;
    case (ea_req_i.mode)
      EA_IND:   ea_d = base_a;
      EA_POST: begin
        ea_d   = base_a;
        an_upd = 1'b1;
        an_new = base_a + step_of(ea_req_i.size, ea_req_i.areg);
      end
      EA_PRE: begin
        an_upd = 1'b1;
        an_new = base_a - step_of(ea_req_i.size, ea_req_i.areg);
        ea_d   = an_new;
      end
      EA_DISP:  ea_d = base_a + sext16(ea_req_i.ext0);
      EA_INDEX: ea_d = base_a + xval + sext8(ea_req_i.d8);
      EA_ABSW:  ea_d = sext16(ea_req_i.ext0);
      EA_ABSL:  ea_d = {ea_req_i.ext0, ea_req_i.ext1};
      EA_PCD:   ea_d = program_counter_q + sext16(ea_req_i.ext0);
      EA_PCX:   ea_d = program_counter_q + xval + sext8(ea_req_i.d8);
      EA_IMM: begin
        if (ea_req_i.size == SZ_LONG) begin
          imm_d = {ea_req_i.ext0, ea_req_i.ext1};
        end else begin
          imm_d = {16'h0, ea_req_i.ext0};
        end
      end
      EA_QUICK: imm_d = sext8(ea_req_i.quick);
      default:  ea_d = ZERO32; // register direct has no address
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      effective_address_o <= ZERO32;
      imm_data_o          <= ZERO32;
      ea_valid_o          <= 1'b0;
    end else begin
      ea_valid_o <= ea_req_i.start;
      if (ea_req_i.start) begin
        effective_address_o <= ea_d;
        imm_data_o          <= imm_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // general registers
  // ----------------------------------------------------------------
  logic        wr_an;
  logic        upd_an;
  logic [31:0] an_val;
  logic [2:0]  an_num;

  // address register writes are word (sign-extended) or long only
  always_comb begin
    upd_an = ea_req_i.start && an_upd;
    wr_an  = (reg_wr_i.wr && reg_wr_i.is_addr
              && (reg_wr_i.size == SZ_WORD || reg_wr_i.size == SZ_LONG)) || upd_an;
    an_num = upd_an ? ea_req_i.areg : reg_wr_i.num;
    if (upd_an) begin
      an_val = an_new;
    end else if (reg_wr_i.size == SZ_LONG) begin
      an_val = reg_wr_i.data;
    end else begin
      an_val = sext16(reg_wr_i.data[15:0]);
    end
  end

  // data registers at all three sizes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_DATA; i++) begin
        data_regs[i] <= ZERO32;
      end
    end else if (reg_wr_i.wr && !reg_wr_i.is_addr) begin
      data_regs[reg_wr_i.num] <= size_merge(data_regs[reg_wr_i.num],
                                            reg_wr_i.data, reg_wr_i.size);
    end
  end

  // address registers and the banked stack pointers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_ADDR-1; i++) begin
        addr_regs[i] <= ZERO32;
      end
      user_stack_ptr_q <= ZERO32;
      supv_stack_ptr_q <= ZERO32;
    end else if (wr_an) begin
      if (an_num != STACK_AREG) begin
        addr_regs[an_num] <= an_val;
      end else if (supv) begin
        supv_stack_ptr_q <= an_val;
      end else begin
        user_stack_ptr_q <= an_val;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= ZERO32;
    end else begin
      rd_data_o <= gen_rd(rd_idx_i);
    end
  end

  // ----------------------------------------------------------------
  // program counter and status word
  // ----------------------------------------------------------------
  logic sr_ok;
  assign sr_ok = sr_wr_i && supv;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      program_counter_q <= PC_RST;
    end else if (pc_wr_i) begin
      program_counter_q <= pc_data_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_word_q <= SR_RST;
    end else if (sr_ok) begin
      status_word_q <= sr_data_i & SR_IMPL;
    end else if (flag_wr_i.wr) begin
      status_word_q[CF_X:CF_C] <= flag_wr_i.cond_flag_byte;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      priv_viol_o <= 1'b0;
    end else begin
      priv_viol_o <= (priv_op_i || sr_wr_i) && !supv;
    end
  end

  assign program_counter_o = program_counter_q;
  assign status_word_o     = status_word_q;

  // ----------------------------------------------------------------
  // long word over the 16-bit data path
  // ----------------------------------------------------------------
  cpm_xfer_t   xf_q;
  logic [15:0] lo_hold_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xf_q         <= XF_IDLE;
      lo_hold_q    <= 16'h0;
      bus_data_o   <= 16'h0;
      bus_strobe_o <= 1'b0;
      xfer_busy_o  <= 1'b0;
    end else begin
      case (xf_q)
        XF_IDLE: begin
          bus_strobe_o <= 1'b0;
          xfer_busy_o  <= 1'b0;
          if (xfer_start_i) begin
            bus_data_o   <= xfer_data_i[31:16]; // high word first
            lo_hold_q    <= xfer_data_i[15:0];
            bus_strobe_o <= 1'b1;
            xfer_busy_o  <= 1'b1;
            xf_q         <= XF_HI;
          end
        end
        XF_HI: begin
          bus_data_o <= lo_hold_q; // second access
          xf_q       <= XF_LO;
        end
        XF_LO: begin
          bus_strobe_o <= 1'b0;
          xfer_busy_o  <= 1'b0;
          xf_q         <= XF_IDLE;
        end
        default: xf_q <= XF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_user_sp_bank: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_idx_i == 4'hf && !supv) |=> rd_data_o == $past(user_stack_ptr_q))
    else $error("user stack pointer not selected");
  a_supv_sp_bank: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (rd_idx_i == 4'hf && supv) |=> rd_data_o == $past(supv_stack_ptr_q))
    else $error("supervisor stack pointer not selected");
  a_sr_guard: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sr_wr_i && !supv && !flag_wr_i.wr) |=> $stable(status_word_q))
    else $error("status word written from user privilege");
  a_priv_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (priv_op_i && !supv) |=> priv_viol_o)
    else $error("privileged operation not flagged");
  a_pc_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pc_wr_i |=> program_counter_o == $past(pc_data_i))
    else $error("program counter not loaded");
  a_post_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ea_req_i.start && ea_req_i.mode == EA_POST && ea_req_i.size == SZ_LONG
     && ea_req_i.areg != STACK_AREG)
    |=> addr_regs[$past(ea_req_i.areg)] == $past(base_a) + 32'h4)
    else $error("post-increment step wrong");
  a_pcd_addr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ea_req_i.start && ea_req_i.mode == EA_PCD)
    |=> effective_address_o == $past(program_counter_q) + sext16($past(ea_req_i.ext0)))
    else $error("relative address wrong");
  a_absw_addr: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (ea_req_i.start && ea_req_i.mode == EA_ABSW)
    |=> effective_address_o == sext16($past(ea_req_i.ext0)))
    else $error("absolute short address wrong");

  sequence s_two_words;
    bus_strobe_o [*2] ##1 !bus_strobe_o;
  endsequence
  a_long_split: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (xfer_start_i && xf_q == XF_IDLE) |=> s_two_words)
    else $error("long word not split in two accesses");

endmodule : cpm_regfile

`default_nettype wire

// >>> dv/test_cpu_programming_model.sv
// self-checking bench for the core register file and address unit
`timescale 1ns/1ps
`default_nettype none

module test_cpu_programming_model
  import cpm_pkg::*;
;
  logic         core_clk_i;
  logic         rst_i;
  cpm_reg_wr_t  reg_wr;
  logic [3:0]   rd_idx;
  cpm_flag_wr_t flag_wr;
  logic         sr_wr;
  logic [15:0]  sr_data;
  logic         priv_op;
  logic         pc_wr;
  logic [31:0]  pc_data;
  cpm_ea_req_t  ea_req;
  logic         xfer_start;
  logic [31:0]  xfer_data;
  logic [31:0]  rd_data, pc_q, ea_q, imm_q;
  logic [15:0]  sw_q, bus_q;
  logic         ea_vld, viol, strobe, busy;
  int           mismatches;
  int           compares;
  int           cycles;

  cpm_regfile DUT (
    .core_clk_i          (core_clk_i),
    .rst_i               (rst_i),
    .reg_wr_i            (reg_wr),
    .rd_idx_i            (rd_idx),
    .flag_wr_i           (flag_wr),
    .sr_wr_i             (sr_wr),
    .sr_data_i           (sr_data),
    .priv_op_i           (priv_op),
    .pc_wr_i             (pc_wr),
    .pc_data_i           (pc_data),
    .ea_req_i            (ea_req),
    .xfer_start_i        (xfer_start),
    .xfer_data_i         (xfer_data),
    .rd_data_o           (rd_data),
    .program_counter_o   (pc_q),
    .status_word_o       (sw_q),
    .effective_address_o (ea_q),
    .imm_data_o          (imm_q),
    .ea_valid_o          (ea_vld),
    .priv_viol_o         (viol),
    .bus_data_o          (bus_q),
    .bus_strobe_o        (strobe),
    .xfer_busy_o         (busy)
  );

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // cut a hang short after far more cycles than the tests need
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic a, input logic [2:0] n, input cpm_size_t s,
                        input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr <= '{1'b1, a, n, s, d};
    @(posedge core_clk_i);
    reg_wr.wr <= 1'b0;
  endtask : wr_reg

  // read data lands one cycle after the select is driven
  task automatic rd_chk(input logic [3:0] i, input logic [31:0] exp);
    @(posedge core_clk_i);
    rd_idx <= i;
    @(posedge core_clk_i);
    #1 chk(rd_data, exp, "register read");
  endtask : rd_chk

  task automatic ea_chk(input cpm_mode_t m, input cpm_size_t s, input logic [2:0] ar,
                        input logic [3:0] xi, input logic [7:0] d8, input logic [15:0] e0,
                        input logic [15:0] e1, input logic [31:0] x_ea, input logic ci,
                        input logic [31:0] x_imm);
    @(posedge core_clk_i);
    ea_req <= '{1'b1, m, s, ar, xi, (s == SZ_LONG), d8, e0, e1, d8};
    @(posedge core_clk_i);
    ea_req.start <= 1'b0;
    #1 chk({31'h0, ea_vld}, 32'h1, "address valid");
    if (ci) chk(imm_q, x_imm, "immediate data");
    else chk(ea_q, x_ea, "effective address");
  endtask : ea_chk

  // status write, flag write or privileged attempt, then viol and status
  task automatic ctl(input logic sw, input logic [15:0] sd, input logic fw,
                     input logic [4:0] cc, input logic po, input logic xv,
                     input logic [15:0] xs);
    @(posedge core_clk_i);
    sr_wr   <= sw;
    sr_data <= sd;
    flag_wr <= '{fw, cc};
    priv_op <= po;
    @(posedge core_clk_i);
    sr_wr   <= 1'b0;
    flag_wr <= '{1'b0, 5'h00};
    priv_op <= 1'b0;
    #1 chk({31'h0, viol}, {31'h0, xv}, "privilege refusal");
    chk({16'h0, sw_q}, {16'h0, xs}, "status word");
  endtask : ctl

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    reg_wr = '0;
    rd_idx = 4'h0;
    flag_wr = '0;
    sr_wr = 1'b0;
    sr_data = 16'h0000;
    priv_op = 1'b0;
    pc_wr = 1'b0;
    pc_data = 32'h0;
    ea_req = '0;
    xfer_start = 1'b0;
    xfer_data = 32'h0;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1 chk({16'h0, sw_q}, 32'h0000_2700, "status after reset");
    chk(pc_q, 32'h0, "counter after reset");
    // data register sizes merge into the low part
    wr_reg(1'b0, 3'h3, SZ_LONG, 32'h1234_5678);
    wr_reg(1'b0, 3'h3, SZ_BYTE, 32'h0000_00ab);
    rd_chk(4'h3, 32'h1234_56ab);
    wr_reg(1'b0, 3'h3, SZ_WORD, 32'h0000_cdef);
    rd_chk(4'h3, 32'h1234_cdef);
    wr_reg(1'b0, 3'h4, SZ_BCD, 32'h0000_0099);
    rd_chk(4'h4, 32'h0000_0099);
    // address registers: word sign-extends, byte is ignored
    wr_reg(1'b1, 3'h1, SZ_LONG, 32'h0000_1000);
    wr_reg(1'b1, 3'h2, SZ_WORD, 32'h0000_8001);
    wr_reg(1'b1, 3'h2, SZ_BYTE, 32'h0000_0055);
    wr_reg(1'b1, 3'h2, SZ_BCD, 32'h0000_0055);
    rd_chk(4'ha, 32'hffff_8001);
    wr_reg(1'b1, 3'h7, SZ_LONG, 32'h0000_2000);
    rd_chk(4'hf, 32'h0000_2000);
    // indirect forms, index from data and address registers
    ea_chk(EA_IND, SZ_LONG, 3'h1, 4'h0, 8'h00, 16'h0, 16'h0, 32'h0000_1000, 0, 0);
    ea_chk(EA_DISP, SZ_LONG, 3'h1, 4'h0, 8'h00, 16'hfff0, 16'h0, 32'h0000_0ff0, 0, 0);
    ea_chk(EA_INDEX, SZ_WORD, 3'h1, 4'h3, 8'h10, 16'h0, 16'h0, 32'hffff_ddff, 0, 0);
    ea_chk(EA_INDEX, SZ_WORD, 3'h1, 4'ha, 8'hfe, 16'h0, 16'h0, 32'hffff_8fff, 0, 0);
    ea_chk(EA_INDEX, SZ_LONG, 3'h1, 4'h3, 8'h10, 16'h0, 16'h0, 32'h1234_ddff, 0, 0);
    ea_chk(EA_DREG, SZ_LONG, 3'h1, 4'h0, 8'h00, 16'h0, 16'h0, 32'h0, 0, 0);
    // steps follow the size, byte on the stack pointer steps two
    ea_chk(EA_POST, SZ_LONG, 3'h1, 4'h0, 8'h00, 16'h0, 16'h0, 32'h0000_1000, 0, 0);
    rd_chk(4'h9, 32'h0000_1004);
    ea_chk(EA_PRE, SZ_WORD, 3'h1, 4'h0, 8'h00, 16'h0, 16'h0, 32'h0000_1002, 0, 0);
    ea_chk(EA_POST, SZ_BYTE, 3'h1, 4'h0, 8'h00, 16'h0, 16'h0, 32'h0000_1002, 0, 0);
    rd_chk(4'h9, 32'h0000_1003);
    ea_chk(EA_PRE, SZ_BYTE, 3'h7, 4'h0, 8'h00, 16'h0, 16'h0, 32'h0000_1ffe, 0, 0);
    rd_chk(4'hf, 32'h0000_1ffe);
    // counter-relative, absolute, immediate and quick forms
    @(posedge core_clk_i);
    pc_wr <= 1'b1;
    pc_data <= 32'h0000_4000;
    @(posedge core_clk_i);
    pc_wr <= 1'b0;
    ea_chk(EA_PCD, SZ_WORD, 3'h0, 4'h0, 8'h00, 16'h0100, 16'h0, 32'h0000_4100, 0, 0);
    ea_chk(EA_PCX, SZ_WORD, 3'h0, 4'h3, 8'h02, 16'h0, 16'h0, 32'h0000_0df1, 0, 0);
    ea_chk(EA_ABSW, SZ_WORD, 3'h0, 4'h0, 8'h00, 16'h1234, 16'h0, 32'h0000_1234, 0, 0);
    ea_chk(EA_ABSL, SZ_LONG, 3'h0, 4'h0, 8'h00, 16'hdead, 16'hbeef, 32'hdead_beef, 0, 0);
    ea_chk(EA_IMM, SZ_WORD, 3'h0, 4'h0, 8'h00, 16'h8765, 16'h0, 0, 1, 32'h0000_8765);
    ea_chk(EA_IMM, SZ_LONG, 3'h0, 4'h0, 8'h00, 16'h1234, 16'h5678, 0, 1, 32'h1234_5678);
    ea_chk(EA_QUICK, SZ_LONG, 3'h0, 4'h0, 8'hfe, 16'h0, 16'h0, 0, 1, 32'hffff_fffe);
    // long word over the narrow path, high half first
    @(posedge core_clk_i);
    xfer_start <= 1'b1;
    xfer_data <= 32'hdead_beef;
    @(posedge core_clk_i);
    xfer_start <= 1'b0;
    #1 chk({14'h0, busy, strobe, bus_q}, {14'h0, 2'b11, 16'hdead}, "high half");
    @(posedge core_clk_i);
    #1 chk({14'h0, busy, strobe, bus_q}, {14'h0, 2'b11, 16'hbeef}, "low half");
    @(posedge core_clk_i);
    #1 chk({30'h0, busy, strobe}, 32'h0, "transfer end");
    // privilege: flags, full status, drop to user, refusals
    ctl(0, 16'h0, 1, 5'h15, 1, 0, 16'h2715);
    ctl(1, 16'hffff, 0, 5'h00, 0, 0, 16'ha71f);
    ctl(1, 16'h0000, 0, 5'h00, 0, 0, 16'h0000);
    ctl(1, 16'h2700, 0, 5'h00, 0, 1, 16'h0000);
    ctl(0, 16'h0, 1, 5'h0a, 0, 0, 16'h000a);
    ctl(0, 16'h0, 0, 5'h00, 1, 1, 16'h000a);
    wr_reg(1'b1, 3'h7, SZ_LONG, 32'h0000_3000);
    rd_chk(4'hf, 32'h0000_3000);
    chk(pc_q, 32'h0000_4000, "counter in user");
    tally_and_finish();
  end

endmodule : test_cpu_programming_model

`default_nettype wire
